// file: logic/lca_regs.svh
// Register indices, field positions, reset values and timing counts of the line alarm block
`ifndef LCA_REGS_SVH
`define LCA_REGS_SVH

`define LCA_NUM_CH 16
`define LCA_CH_W 4
`define LCA_ADDR_W 12

`define LCA_IDX_ERR_MASK 6'h1D
`define LCA_IDX_STATE_A 6'h1E
`define LCA_IDX_STATE_B 6'h1F
`define LCA_IDX_FLAGS_A 6'h20
`define LCA_IDX_CTRL 6'h3C
`define LCA_IDX_EDGE_SEL 6'h3D
`define LCA_IDX_FLAGS_MASK 6'h3E
`define LCA_IDX_ERR_FLAGS 6'h3F

`define LCA_MASK_RST 8'hFF
`define LCA_ERR_MASK_RST 8'h3F
`define LCA_EDGE_RST 8'h00
`define LCA_CTRL_RST 8'h00
`define LCA_STATE_RST 8'h00
`define LCA_FLAGS_RST 8'h00

`define LCA_ERR_BITS 8'h3F
`define LCA_EDGE_BITS 8'h1E
`define LCA_CTRL_BITS 8'h03

`define LCA_ES_OC 4
`define LCA_ES_CLK 3
`define LCA_ES_TX 2
`define LCA_ES_LOS 1
`define LCA_CTRL_AUTOLB 0
`define LCA_CTRL_E1 1
`define LCA_EM_CNTOV 0
`define LCA_EM_PATERR 1

`define LCA_RESP_OKAY 2'h0
`define LCA_RESP_SLVERR 2'h2

`define LCA_CLK_MHZ 200
`define LCA_IB_SHORT_MS 40
`define LCA_IB_E1_MS 30
`define LCA_IB_LONG_DECI_S 51
`define LCA_IB_SHORT_CYC (`LCA_IB_SHORT_MS * 1000 * `LCA_CLK_MHZ)
`define LCA_IB_E1_CYC (`LCA_IB_E1_MS * 1000 * `LCA_CLK_MHZ)
`define LCA_IB_LONG_CYC (`LCA_IB_LONG_DECI_S * 100000 * `LCA_CLK_MHZ)

`endif

// file: logic/lca_pkg.sv
// Types shared by the line alarm block
package lca_pkg;

	typedef struct packed {
		logic auto_loopback_state;
		logic driver_overcurrent_state;
		logic tx_clock_loss_state;
		logic tx_signal_loss_state;
		logic sys_signal_loss_state;
		logic line_signal_loss_state;
		logic sys_alarm_indication_state;
		logic line_alarm_indication_state;
		logic pattern_sync_state;
		logic inband_activate_seen;
		logic inband_deactivate_seen;
		logic amplitude_overflow_event;
		logic tx_jitter_fifo_event;
		logic rx_jitter_fifo_event;
		logic [5:0] error_event;
	} lca_det_t;

endpackage

// file: logic/lca_alarm_top.sv
// Per-channel alarm status, sticky event flags, masks and AXI4-Lite access for all line channels
//
// Overview of operation
// RULE1: Register set repeated per channel, 0x40 stride.
// RULE2: Mask 0 enables, 1 blocks; reset 1.
// RULE3: Error mask bit 0 gates counter overflow.
// RULE4: Error mask bit 1 gates pattern error.
// RULE5: State A bit 7 shows auto loopback.
// RULE6: State A bit 4 shows driver overcurrent.
// RULE7: State A bit 3 shows transmit clock missing.
// RULE8: State A bit 2 shows transmit signal loss.
// RULE9: State A bits 1,0 show system/line loss.
// RULE10: State B bits 7,6 show system/line AIS.
// RULE11: State B bit 5 shows pattern sync.
// RULE12: State B bit 1 after long activate code.
// RULE13: State B bit 0 after long deactivate code.
// RULE14: State registers read-only, live, reset zero.
// RULE15: Flags sticky, reach interrupt, write one clears.
// RULE16: Overcurrent flag on rise, or both edges.
// RULE17: Clock loss flag on rise, or both edges.
// RULE18: Transmit loss flag on rise, or both edges.
// RULE19: Both loss flags share one edge select.
// RULE20: Flag bit 7 latches amplitude overflow.
// RULE21: Flag bits 6,5 latch jitter FIFO faults.
// RULE22: Edge selects reset to rising edge only.
// RULE23: Interrupt when any unmasked flag is set.
// RULE24: Reserved bits ignore writes, read zero.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`include "lca_regs.svh"

module lca_alarm_top #(
	parameter int unsigned IB_SHORT_CYC = `LCA_IB_SHORT_CYC,
	parameter int unsigned IB_E1_CYC = `LCA_IB_E1_CYC,
	parameter int unsigned IB_LONG_CYC = `LCA_IB_LONG_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [`LCA_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`LCA_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire lca_pkg::lca_det_t [`LCA_NUM_CH-1:0] det,
	output logic irq
);

	// Write channel capture
	logic aw_held;
	logic w_held;
	logic [`LCA_ADDR_W-1:0] aw_addr;
	logic [7:0] w_data;
	logic w_lane0;
	logic wr_go;
	logic [`LCA_CH_W-1:0] wr_ch;
	logic [5:0] wr_idx;
	logic wr_mapped;
	logic [`LCA_CH_W-1:0] rd_ch;
	logic [5:0] rd_idx;
	logic [7:0] rd_byte;
	logic rd_mapped;

	// Per-channel register images, each element written by its own channel only
	logic [7:0] err_mask [`LCA_NUM_CH];
	logic [7:0] edge_sel [`LCA_NUM_CH];
	logic [7:0] ctrl [`LCA_NUM_CH];
	logic [7:0] flag_mask [`LCA_NUM_CH];
	logic [7:0] state_a [`LCA_NUM_CH];
	logic [7:0] state_b [`LCA_NUM_CH];
	logic [7:0] flags_a [`LCA_NUM_CH];
	logic [7:0] err_flags [`LCA_NUM_CH];
	logic [`LCA_NUM_CH-1:0] ch_irq;

	// Stalls while a response waits, so one write is in flight
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wr_ch = aw_addr[11:8]; // [RULE1]
	assign wr_idx = aw_addr[7:2];
	assign rd_ch = s_axi_araddr[11:8]; // [RULE1]
	assign rd_idx = s_axi_araddr[7:2];

	always_comb begin
		case (wr_idx)
			`LCA_IDX_ERR_MASK, `LCA_IDX_STATE_A, `LCA_IDX_STATE_B, `LCA_IDX_FLAGS_A,
			`LCA_IDX_CTRL, `LCA_IDX_EDGE_SEL, `LCA_IDX_FLAGS_MASK, `LCA_IDX_ERR_FLAGS: begin
				wr_mapped = 1'b1;
			end
			default: begin
				wr_mapped = 1'b0;
			end
		endcase
	end

	// Unused bits read as zero since every image keeps them at zero
	always_comb begin
		rd_mapped = 1'b1;
		case (rd_idx)
			`LCA_IDX_ERR_MASK: begin
				rd_byte = err_mask[rd_ch];
			end
			`LCA_IDX_STATE_A: begin
				rd_byte = state_a[rd_ch];
			end
			`LCA_IDX_STATE_B: begin
				rd_byte = state_b[rd_ch];
			end
			`LCA_IDX_FLAGS_A: begin
				rd_byte = flags_a[rd_ch];
			end
			`LCA_IDX_CTRL: begin
				rd_byte = ctrl[rd_ch];
			end
			`LCA_IDX_EDGE_SEL: begin
				rd_byte = edge_sel[rd_ch];
			end
			`LCA_IDX_FLAGS_MASK: begin
				rd_byte = flag_mask[rd_ch];
			end
			`LCA_IDX_ERR_FLAGS: begin
				rd_byte = err_flags[rd_ch];
			end
			default: begin
				rd_byte = 8'h00;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// Address and data are taken in either order; the write happens once both are held
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			aw_held <= 1'b0;
			aw_addr <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_wready <= 1'b1;
			w_held <= 1'b0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_held <= 1'b1;
			w_data <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
		end else if (wr_go) begin
			w_held <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `LCA_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? `LCA_RESP_OKAY : `LCA_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Reads have no side effects, so data is sampled straight off the address
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `LCA_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= rd_mapped ? `LCA_RESP_OKAY : `LCA_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `LCA_NUM_CH; g++) begin : gen_ch
			logic wr_here;
			logic wr_err_mask;
			logic wr_flag_mask;
			logic wr_edge_sel;
			logic wr_ctrl;
			logic clr_flags_a;
			logic clr_err_flags;
			logic act_hit;
			logic deact_hit;
			logic flag_hit;
			logic err_hit;
			logic [4:0] prev_a;
			logic [4:0] sel_vec;
			logic [7:0] set_a;
			logic [7:0] set_e;
			logic [7:0] clr;
			logic [31:0] act_cnt;
			logic [31:0] deact_cnt;
			logic [31:0] act_lim;
			logic [31:0] deact_lim;
			logic autolb;

			assign wr_here = wr_go && w_lane0 && (wr_ch == `LCA_CH_W'(g)); // [RULE1]

			// Write strobes per register, decoded once
			assign wr_err_mask = wr_here && (wr_idx == `LCA_IDX_ERR_MASK);
			assign wr_flag_mask = wr_here && (wr_idx == `LCA_IDX_FLAGS_MASK);
			assign wr_edge_sel = wr_here && (wr_idx == `LCA_IDX_EDGE_SEL);
			assign wr_ctrl = wr_here && (wr_idx == `LCA_IDX_CTRL);
			assign clr_flags_a = wr_here && (wr_idx == `LCA_IDX_FLAGS_A); // [RULE15]
			assign clr_err_flags = wr_here && (wr_idx == `LCA_IDX_ERR_FLAGS);
			assign autolb = ctrl[g][`LCA_CTRL_AUTOLB];
			assign act_lim = autolb ? 32'(IB_LONG_CYC) : 32'(IB_SHORT_CYC); // [RULE12]
			assign deact_lim = autolb ? 32'(IB_LONG_CYC) :
				(ctrl[g][`LCA_CTRL_E1] ? 32'(IB_E1_CYC) : 32'(IB_SHORT_CYC)); // [RULE13]

			always_ff @(posedge mclk) begin
				if (rst) begin
					err_mask[g] <= `LCA_ERR_MASK_RST; // [RULE2]
				end else if (wr_err_mask) begin
					err_mask[g] <= w_data & `LCA_ERR_BITS; // [RULE4] [RULE24]
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					flag_mask[g] <= `LCA_MASK_RST; // [RULE2]
				end else if (wr_flag_mask) begin
					flag_mask[g] <= w_data;
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					edge_sel[g] <= `LCA_EDGE_RST; // [RULE22]
				end else if (wr_edge_sel) begin
					edge_sel[g] <= w_data & `LCA_EDGE_BITS; // [RULE24]
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					ctrl[g] <= `LCA_CTRL_RST;
				end else if (wr_ctrl) begin
					ctrl[g] <= w_data & `LCA_CTRL_BITS; // [RULE24]
				end
			end

			// Code must persist beyond the limit; the count saturates just past it
			always_ff @(posedge mclk) begin
				if (rst) begin
					act_cnt <= 32'h00000000;
				end else if (!det[g].inband_activate_seen) begin
					act_cnt <= 32'h00000000;
				end else if (act_cnt <= act_lim) begin
					act_cnt <= act_cnt + 32'h00000001; // [RULE12]
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					deact_cnt <= 32'h00000000;
				end else if (!det[g].inband_deactivate_seen) begin
					deact_cnt <= 32'h00000000;
				end else if (deact_cnt <= deact_lim) begin
					deact_cnt <= deact_cnt + 32'h00000001; // [RULE13]
				end
			end

			assign act_hit = act_cnt > act_lim; // [RULE12]
			assign deact_hit = deact_cnt > deact_lim; // [RULE13]

			always_ff @(posedge mclk) begin
				if (rst) begin
					state_a[g] <= `LCA_STATE_RST; // [RULE14]
				end else begin
					state_a[g] <= {det[g].auto_loopback_state, 2'h0, // [RULE5]
						det[g].driver_overcurrent_state, // [RULE6]
						det[g].tx_clock_loss_state, // [RULE7]
						det[g].tx_signal_loss_state, // [RULE8]
						det[g].sys_signal_loss_state, det[g].line_signal_loss_state}; // [RULE9]
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					state_b[g] <= `LCA_STATE_RST; // [RULE14]
				end else begin
					state_b[g] <= {det[g].sys_alarm_indication_state, det[g].line_alarm_indication_state, // [RULE10]
						det[g].pattern_sync_state, 3'h0, // [RULE11]
						act_hit, deact_hit}; // [RULE12] [RULE13]
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					prev_a <= 5'h00;
				end else begin
					prev_a <= state_a[g][4:0];
				end
			end

			// One select bit serves both loss flags
			assign sel_vec = {edge_sel[g][`LCA_ES_OC], // [RULE16]
				edge_sel[g][`LCA_ES_CLK], // [RULE17]
				edge_sel[g][`LCA_ES_TX], // [RULE18]
				edge_sel[g][`LCA_ES_LOS], edge_sel[g][`LCA_ES_LOS]}; // [RULE19]
			assign set_a[4:0] = (state_a[g][4:0] & ~prev_a) | ((state_a[g][4:0] ^ prev_a) & sel_vec); // [RULE22]
			assign set_a[7] = det[g].amplitude_overflow_event; // [RULE20]
			assign set_a[6] = det[g].tx_jitter_fifo_event; // [RULE21]
			assign set_a[5] = det[g].rx_jitter_fifo_event; // [RULE21]
			assign set_e = {2'h0, det[g].error_event};
			assign clr = w_data;

			// A new event in the clearing cycle wins over the clear
			always_ff @(posedge mclk) begin
				if (rst) begin
					flags_a[g] <= `LCA_FLAGS_RST; // [RULE15]
				end else if (clr_flags_a) begin
					flags_a[g] <= (flags_a[g] & ~clr) | set_a; // [RULE15]
				end else begin
					flags_a[g] <= flags_a[g] | set_a; // [RULE15]
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					err_flags[g] <= `LCA_FLAGS_RST;
				end else if (clr_err_flags) begin
					err_flags[g] <= (err_flags[g] & ~clr & `LCA_ERR_BITS) | set_e; // [RULE15] [RULE24]
				end else begin
					err_flags[g] <= err_flags[g] | set_e;
				end
			end

			assign flag_hit = |(flags_a[g] & ~flag_mask[g]); // [RULE2] [RULE15]
			// Reserved error bits can never raise the line
			assign err_hit = |(err_flags[g] & ~err_mask[g] & `LCA_ERR_BITS); // [RULE3] [RULE4]
			assign ch_irq[g] = flag_hit | err_hit; // [RULE23]
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |ch_irq; // [RULE23]
		end
	end

endmodule // lca_alarm_top

// file: tb/lca_alarm_chk.sv
// Bus and interrupt checker bound to the line alarm top
`timescale 1ns/100ps
module lca_alarm_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid) else $error("write unanswered");
	rd_answer_a: assert property (rd_take |-> ##[1:2] s_axi_rvalid) else $error("read unanswered");
	wr_busy_a: assert property (wr_take |=> !s_axi_awready && !s_axi_wready) else $error("ready high");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready high");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
	rdata_high_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata high");
	irq_reset_a: assert property (disable iff (1'b0) rst |=> !irq) else $error("irq in reset");
endmodule // lca_alarm_chk

bind lca_alarm_top lca_alarm_chk i_chk (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .irq);

// file: tb/lca_alarm_tb_top.sv
// Self-checking bench for the line alarm block
`timescale 1ns/100ps
module lca_alarm_tb_top;
	logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, ch;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	lca_pkg::lca_det_t [15:0] det;
	logic [8:0] nv;
	logic [7:0] fl, sel, sb, ov, es;
	int bad_count = 0;
	int cmp_count = 0;
	int i;
	// Short inband limits keep the run brief
	lca_alarm_top #(.IB_SHORT_CYC(20), .IB_E1_CYC(15), .IB_LONG_CYC(50)) i_dut (.mclk, .rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .det, .irq);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] ix, input logic [7:0] d, input logic [1:0] er = 2'h0);
		s_axi_awaddr <= {ch, ix, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		fork
			begin
				do @(posedge mclk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge mclk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge mclk); while (!s_axi_bvalid);
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic rd(input logic [5:0] ix, input logic [7:0] e, input string n, input logic [1:0] er = 2'h0);
		s_axi_araddr <= {ch, ix, 2'h0};
		s_axi_arvalid <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (!s_axi_rvalid);
		chk(n, {24'h0, e}, s_axi_rdata);
		chk(n, er, s_axi_rresp);
	endtask
	// Code held just short of its limit, then past it
	task automatic ib(input logic [7:0] ctl, input int b, input int lim, input string n);
		wr(6'h3C, ctl);
		det[ch][10 - b] <= 1'b1;
		repeat (lim - 4) @(posedge mclk);
		rd(6'h1F, sb, n);
		repeat (8) @(posedge mclk);
		rd(6'h1F, sb | (8'h2 >> b), n);
		det[ch][10 - b] <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic finish_test();
		if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#40000;
		bad_count++;
		finish_test();
	end
	initial begin
		{rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		det = '0;
		{fl, sel, ov} = '0;
		void'($urandom(29018));
		ch = 4'($urandom);
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(6'h1D, 8'h3F, "err_mask");
		rd(6'h3E, 8'hFF, "flag_mask");
		rd(6'h1E, 8'h0, "state_a");
		rd(6'h1F, 8'h0, "state_b");
		rd(6'h20, 8'h0, "flags");
		rd(6'h3D, 8'h0, "edge_sel");
		s_axi_wstrb <= 4'hE;
		wr(6'h3E, 8'h00);
		s_axi_wstrb <= 4'hF;
		rd(6'h3E, 8'hFF, "strb_off");
		wr(6'h1D, 8'hFF);
		rd(6'h1D, 8'h3F, "err_rsvd");
		wr(6'h1E, 8'hFF);
		rd(6'h1E, 8'h0, "state_ro");
		wr(6'h10, 8'h01, 2'h2);
		rd(6'h10, 8'h0, "unmapped", 2'h2);
		for (i = 0; i < 12; i++) begin
			if (i == 6) begin
				es = 8'($urandom) & 8'h1E;
				sel = {3'h0, es[4:1], es[1]};
				wr(6'h3D, es);
			end
			nv = 9'($urandom);
			det[ch][19:11] <= {nv[5:0], nv[8:6]};
			fl |= ({3'h0, nv[4:0]} & ~ov) | (sel & ov & ~{3'h0, nv[4:0]});
			ov = {3'h0, nv[4:0]};
			sb = {nv[8:6], 5'h0};
			repeat (3) @(posedge mclk);
			rd(6'h1E, {nv[5], 2'h0, nv[4:0]}, "state_a");
			rd(6'h1F, sb, "state_b");
			rd(6'h20, fl, "flags");
			chk("irq_masked", 0, irq);
		end
		ch = ch + 4'h1;
		rd(6'h1E, 8'h0, "other_ch");
		ch = ch - 4'h1;
		wr(6'h20, 8'h0F);
		rd(6'h20, fl & 8'hF0, "w1c_part");
		wr(6'h3E, 8'h0);
		repeat (2) @(posedge mclk);
		chk("irq_on", fl[4], irq);
		wr(6'h20, 8'hFF);
		repeat (2) @(posedge mclk);
		chk("irq_off", 0, irq);
		det[ch][8:6] <= 3'h5;
		@(posedge mclk);
		det[ch][8:6] <= 3'h2;
		@(posedge mclk);
		det[ch][8:6] <= 3'h0;
		rd(6'h20, 8'hE0, "events");
		chk("irq_event", 1, irq);
		wr(6'h20, 8'hFF);
		wr(6'h3E, 8'hFF);
		wr(6'h1D, 8'h3D);
		det[ch][5:0] <= 6'h1;
		@(posedge mclk);
		det[ch][5:0] <= 6'h0;
		repeat (3) @(posedge mclk);
		chk("cnt_masked", 0, irq);
		wr(6'h3F, 8'h3F);
		det[ch][5:0] <= 6'h2;
		@(posedge mclk);
		det[ch][5:0] <= 6'h0;
		repeat (3) @(posedge mclk);
		chk("pat_err", 1, irq);
		wr(6'h3F, 8'h3F);
		ib(8'h0, 0, 20, "ib_act");
		ib(8'h0, 1, 20, "ib_deact");
		ib(8'h2, 1, 15, "ib_deact_e1");
		ib(8'h1, 0, 50, "ib_act_long");
		ib(8'h1, 1, 50, "ib_deact_long");
		finish_test();
	end
endmodule // lca_alarm_tb_top
